// ---- rtl/bdc_pkg.sv ----
// Package of constants and types for the background debug control block.
// Summary of operation
// - On activation by background command, background instruction or breakpoint the CPU condition codes are copied into the holding register.
// - Holding register resets to D8 in special single-chip mode, else zero.
// - Holding register is writable by debug path and feeds restored condition codes.
// - Page register bit 7 enables program-page addressing for debug accesses.
// - Debug register commands never make global accesses, whatever the global enable.
// - Page register bits 3..0 hold page index, bits 6..4 read zero.
// - Read-only 8-bit family identifier is visible at fixed address while active.
// - Two command classes: memory-access commands and CPU-resource commands.
// - Memory-access commands are accepted any time except when secured outside special single-chip mode or during the erase check.
// - CPU-resource commands run only when unsecured and debug is active.
// - Secured special reset: erased flash sets unsecure and enable, all commands allowed.
// - Failed erase check sets only enable; memory commands work, CPU commands do not.
// - Secured device refuses debug outside special single-chip mode.
// - Activation only after enable flag, set by host debug register write.
// - Entry by host background command, background instruction or breakpoint.
// - Breakpoint type picks activation before or after the next instruction.
// - Out of unsecured special single-chip reset debug is enabled and active at once.
// - Activation without enable lets CPU resume; host background commands ignored.
// - While active, registers and firmware table occupy top window, registers lowest twelve.
// - Entry while executing inside the firmware window increments the saved PC by one.
// - Status bit 7 is the enable flag; memory commands still allowed when clear.
package bdc_pkg;
    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [17:0] BDC_WIN_BASE = 18'h3FF00;
    localparam logic [17:0] BDC_REG_LAST = 18'h3FF0B;
    localparam logic [17:0] BDC_STATUS_ADDR = 18'h3FF01;
    localparam logic [17:0] BDC_CCH_ADDR = 18'h3FF06;
    localparam logic [17:0] BDC_PPR_ADDR = 18'h3FF08;
    localparam logic [17:0] BDC_FID_ADDR = 18'h3FF0F;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int BDC_ENABLE_BIT = 7;
    localparam int BDC_ACTIVE_BIT = 6;
    localparam int BDC_UNSECURE_FLAG_BIT = 1;
    localparam int BDC_PAE_BIT = 7;
    localparam logic [7:0] BDC_PPR_WMASK = 8'h8F;
    localparam logic [7:0] BDC_CCH_RST_SPECIAL = 8'hD8;
    localparam logic [7:0] BDC_CCH_RST_OTHER = 8'h00;
    localparam logic [7:0] BDC_PPR_RST = 8'h00;
    // Arbitrary neutral family identifier value.
    localparam logic [7:0] BDC_FAMILY_IDENTIFIER = 8'h5A;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int BDC_CLK_NS = 10;
    localparam int BDC_RESUME_NS = 80;
    localparam int BDC_RESUME_CYC = (BDC_RESUME_NS / BDC_CLK_NS) < 1 ? 1 :
        BDC_RESUME_NS / BDC_CLK_NS;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BDC_CMD_NONE,
        BDC_CMD_MEM,
        BDC_CMD_CPU,
        BDC_CMD_BKGND
    } bdc_cmd_e;
    typedef enum logic [2:0] {
        BDC_RUN,
        BDC_ENTER,
        BDC_ACTIVE,
        BDC_ERASECHK,
        BDC_LOCKED,
        BDC_RESUME
    } bdc_state_e;
endpackage : bdc_pkg

// ---- rtl/bdc_ppr_reg.sv ----
// Program page register with its page access enable and page index.
`timescale 1ns/100ps
`default_nettype none
module bdc_ppr_reg
    import bdc_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic wrEn, // Write strobe.
    input wire logic [7:0] wrData, // Write data.
    output logic [7:0] rdData, // Register contents, unimplemented bits zero.
    output logic pageEnable, // Paged access enable.
    output logic [3:0] pageIndex // Selected program page.
);
    logic [7:0] ppr_reg;

    // Only bit 7 and bits 3..0 store; bits 6..4 stay zero.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ppr_reg <= BDC_PPR_RST;
        end else if (wrEn) begin
            ppr_reg <= wrData & BDC_PPR_WMASK;
        end
    end

    // Field outputs.
    assign rdData = ppr_reg;
    assign pageEnable = ppr_reg[BDC_PAE_BIT];
    assign pageIndex = ppr_reg[3:0];

    unimpl_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        rdData[6:4] == 3'h0) else $error("Unimplemented page bits not zero.");
endmodule : bdc_ppr_reg
`default_nettype wire

// ---- rtl/bdc_resume_timer.sv ----
// Short delay counter that releases the CPU after a refused activation.
`timescale 1ns/100ps
`default_nettype none
module bdc_resume_timer
    import bdc_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic start, // Begin delay.
    output logic done // One-cycle pulse at end of delay.
);
    logic [7:0] cnt_reg;
    logic running_reg;

    // Count down the resume delay.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= 8'h00;
            running_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= 8'(BDC_RESUME_CYC - 1);
            running_reg <= 1'b1;
        end else if (running_reg) begin
            if (cnt_reg == 8'h00) begin
                running_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    assign done = running_reg && (cnt_reg == 8'h00) && !start;
endmodule : bdc_resume_timer
`default_nettype wire

// ---- rtl/bdc_core.sv ----
// Background debug control: security, enable, activation, command gating and registers.
`timescale 1ns/100ps
`default_nettype none
module bdc_core
    import bdc_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic specialMode, // Reset mode is special single-chip.
    input wire logic securedStrap, // Security byte says secured.
    input wire logic flashErased, // Erase check result, valid with flashCheckDone.
    input wire logic flashCheckDone, // Erase check complete pulse.
    input wire logic cmdValid, // Decoded link command pulse.
    input wire bdc_cmd_e cmdClass, // Class of the decoded command.
    input wire logic cmdWrite, // Command writes.
    input wire logic cmdDebugReg, // Command targets debug register space.
    input wire logic cmdGlobal, // Command asks for global access.
    input wire logic cmdExitDebug, // CPU-resource command is the resume command.
    input wire logic [17:0] cmdAddr, // Command address.
    input wire logic [7:0] cmdWrData, // Command write byte.
    input wire logic globalAccessEnable, // Global access setting.
    input wire logic bgndInstr, // CPU background instruction pulse.
    input wire logic brkTrigger, // Breakpoint pulse.
    input wire logic brkBefore, // Breakpoint takes effect before next instruction.
    input wire logic instrDone, // CPU finished an instruction.
    input wire logic [7:0] cpuCcr, // CPU condition code register.
    input wire logic [17:0] cpuPc, // CPU program counter at entry.
    input wire logic [17:0] userAddr, // User program read address.
    output logic memCmdAccept, // Memory-access command allowed.
    output logic cpuCmdAccept, // CPU-resource command allowed.
    output logic globalOut, // Global access applied to command.
    output logic pagedOut, // Paged access applied.
    output logic [3:0] pageOut, // Page index applied.
    output logic debugActive, // Debug mode active.
    output logic debugEnable, // Debug enable flag.
    output logic unsecured, // Unsecure flag.
    output logic cpuHold, // Stall CPU.
    output logic [7:0] ccrRestore, // Condition codes to restore on exit.
    output logic [17:0] savedPc, // Saved program counter.
    output logic [7:0] rdData, // Debug register read data.
    output logic rdHit, // Address hits visible debug window.
    output logic userBlocked // User read of debug window blocked.
);
    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    bdc_state_e state_reg;
    logic enable_reg;
    logic unsecure_flag_reg;
    logic [7:0] cch_reg;
    logic [17:0] pc_reg;
    logic pendEntry_reg;
    logic pendAfter_reg;
    logic [7:0] pprRd;
    logic pageEnable;
    logic [3:0] pageIndex;
    logic timerStart;
    logic timerDone;
    logic entryReq;
    logic enterNow;
    logic allowDebug;
    logic regWrite;
    logic boot_reg;

    // Address in the fixed top window.
    function automatic logic inWindow(input logic [17:0] a);
        return a >= BDC_WIN_BASE;
    endfunction : inWindow

    // Address in the register part of the window.
    function automatic logic inRegs(input logic [17:0] a);
        return (a >= BDC_WIN_BASE) && (a <= BDC_REG_LAST);
    endfunction : inRegs

    // ------------------------------------------------------------------
    // Command gating
    // ------------------------------------------------------------------
    // Secured parts allow debug only in special single-chip mode.
    assign allowDebug = unsecure_flag_reg || (specialMode && state_reg != BDC_ERASECHK);
    // Memory commands ignore the enable flag, not security.
    assign memCmdAccept = cmdValid && cmdClass == BDC_CMD_MEM && allowDebug;
    assign cpuCmdAccept = cmdValid && cmdClass == BDC_CMD_CPU && unsecure_flag_reg
        && state_reg == BDC_ACTIVE;
    // Debug register commands never go global.
    assign globalOut = globalAccessEnable && !cmdDebugReg;
    assign pagedOut = pageEnable;
    assign pageOut = pageIndex;
    assign regWrite = memCmdAccept && cmdWrite && cmdDebugReg;

    // Any activation source.
    assign entryReq = (cmdValid && cmdClass == BDC_CMD_BKGND && enable_reg && allowDebug)
        || bgndInstr || (brkTrigger && brkBefore) || pendEntry_reg;
    assign enterNow = state_reg == BDC_RUN && enable_reg
        && (bgndInstr || (brkTrigger && brkBefore) || pendEntry_reg
            || (cmdValid && cmdClass == BDC_CMD_BKGND && allowDebug))
        && instrDone;
    assign timerStart = state_reg == BDC_RUN && !enable_reg && (bgndInstr || brkTrigger);

    // ------------------------------------------------------------------
    // Pending entries: host command waits for instruction end,
    // after-type breakpoints wait one more instruction.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pendEntry_reg <= 1'b0;
            pendAfter_reg <= 1'b0;
        end else if (state_reg != BDC_RUN || !enable_reg) begin
            pendEntry_reg <= 1'b0;
            pendAfter_reg <= 1'b0;
        end else begin
            if (brkTrigger && !brkBefore) begin
                pendAfter_reg <= 1'b1;
            end else if (pendAfter_reg && instrDone) begin
                pendAfter_reg <= 1'b0;
            end
            if (enterNow) begin
                pendEntry_reg <= 1'b0;
            end else if (entryReq || (pendAfter_reg && instrDone)) begin
                pendEntry_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Main state machine.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= BDC_RUN;
        end else begin
            case (state_reg)
                BDC_RUN: begin
                    if (boot_reg && specialMode) begin
                        state_reg <= BDC_ENTER;
                    end else if (enterNow) begin
                        state_reg <= BDC_ACTIVE;
                    end else if (timerStart) begin
                        state_reg <= BDC_RESUME;
                    end
                end
                BDC_ENTER: begin
                    state_reg <= specialMode && securedStrap ? BDC_ERASECHK : BDC_ACTIVE;
                end
                BDC_ERASECHK: begin
                    if (flashCheckDone) begin
                        state_reg <= flashErased ? BDC_ACTIVE : BDC_LOCKED;
                    end
                end
                BDC_LOCKED: begin
                    state_reg <= BDC_LOCKED;
                end
                BDC_ACTIVE: begin
                    if (cpuCmdAccept && cmdExitDebug) begin
                        state_reg <= BDC_RUN;
                    end
                end
                BDC_RESUME: begin
                    if (timerDone) begin
                        state_reg <= BDC_RUN;
                    end
                end
                default: begin
                    state_reg <= BDC_RUN;
                end
            endcase
        end
    end

    // Special single-chip reset starts debug entry at the first edge after release; when unsecured, debug is active from the second edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Enable and unsecure flags.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable_reg <= 1'b0;
            unsecure_flag_reg <= 1'b0;
        end else if (boot_reg) begin
            unsecure_flag_reg <= !securedStrap;
            enable_reg <= specialMode && !securedStrap;
        end else if (state_reg == BDC_ERASECHK && flashCheckDone) begin
            enable_reg <= 1'b1;
            unsecure_flag_reg <= flashErased;
        end else if (regWrite && cmdAddr == BDC_STATUS_ADDR) begin
            enable_reg <= cmdWrData[BDC_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Condition code holding register and saved PC.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cch_reg <= BDC_CCH_RST_OTHER;
        end else if (boot_reg) begin
            cch_reg <= specialMode ? BDC_CCH_RST_SPECIAL : BDC_CCH_RST_OTHER;
        end else if (enterNow) begin
            cch_reg <= cpuCcr;
        end else if (regWrite && cmdAddr == BDC_CCH_ADDR) begin
            cch_reg <= cmdWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_reg <= 18'h00000;
        end else if (enterNow) begin
            pc_reg <= inWindow(cpuPc) ? cpuPc + 18'h00001 : cpuPc;
        end
    end

    // Page register.
    bdc_ppr_reg u_ppr (
        .core_clk(core_clk),
        .rst(rst),
        .wrEn(regWrite && cmdAddr == BDC_PPR_ADDR),
        .wrData(cmdWrData),
        .rdData(pprRd),
        .pageEnable(pageEnable),
        .pageIndex(pageIndex)
    );

    // Resume delay after a refused activation.
    bdc_resume_timer u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(timerStart),
        .done(timerDone)
    );

    // ------------------------------------------------------------------
    // Read path and outputs.
    // ------------------------------------------------------------------
    assign rdHit = cmdDebugReg && (inRegs(cmdAddr) || cmdAddr == BDC_FID_ADDR);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (memCmdAccept && !cmdWrite && cmdDebugReg) begin
            case (cmdAddr)
                BDC_STATUS_ADDR: rdData <= {enable_reg, state_reg == BDC_ACTIVE,
                    4'h0, unsecure_flag_reg, 1'b0};
                BDC_CCH_ADDR: rdData <= cch_reg;
                BDC_PPR_ADDR: rdData <= pprRd;
                BDC_FID_ADDR: rdData <= state_reg == BDC_ACTIVE ? BDC_FAMILY_IDENTIFIER : 8'h00;
                default: rdData <= 8'h00;
            endcase
        end
    end

    assign userBlocked = state_reg == BDC_ACTIVE && inWindow(userAddr);
    assign debugActive = state_reg == BDC_ACTIVE;
    assign debugEnable = enable_reg;
    assign unsecured = unsecure_flag_reg;
    assign cpuHold = state_reg == BDC_ACTIVE || state_reg == BDC_ERASECHK
        || state_reg == BDC_LOCKED || state_reg == BDC_RESUME;
    assign ccrRestore = cch_reg;
    assign savedPc = pc_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ccr_capture_a: assert property (@(posedge core_clk) disable iff (rst)
        enterNow |=> cch_reg == $past(cpuCcr))
        else $error("Condition codes not saved.");
    cch_reset_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(boot_reg) && specialMode |-> cch_reg == BDC_CCH_RST_SPECIAL)
        else $error("Bad holding reset.");
    cch_write_a: assert property (@(posedge core_clk) disable iff (rst)
        regWrite && cmdAddr == BDC_CCH_ADDR && !enterNow && !boot_reg
        |=> ccrRestore == $past(cmdWrData)) else $error("Holding write lost.");
    no_global_a: assert property (@(posedge core_clk) disable iff (rst)
        cmdDebugReg |-> !globalOut)
        else $error("Global debug register access.");
    cpu_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        cpuCmdAccept |-> unsecured && debugActive)
        else $error("CPU command not gated.");
    secure_mem_a: assert property (@(posedge core_clk) disable iff (rst)
        !unsecured && !specialMode |-> !memCmdAccept)
        else $error("Secured access taken.");
    enable_first_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(debugActive) |-> debugEnable)
        else $error("Active without enable.");
    pc_bump_a: assert property (@(posedge core_clk) disable iff (rst)
        enterNow && inWindow(cpuPc) |=> savedPc == $past(cpuPc) + 18'h00001)
        else $error("Saved PC not incremented.");
    user_block_a: assert property (@(posedge core_clk) disable iff (rst)
        debugActive && userAddr <= BDC_REG_LAST && userAddr >= BDC_WIN_BASE |-> userBlocked)
        else $error("User read of debug registers.");

    enter_c: cover property (@(posedge core_clk) disable iff (rst) $rose(debugActive));
    exit_c: cover property (@(posedge core_clk) disable iff (rst) $fell(debugActive));
    locked_c: cover property (@(posedge core_clk) disable iff (rst) state_reg == BDC_LOCKED);
    resume_c: cover property (@(posedge core_clk) disable iff (rst) timerDone);
endmodule : bdc_core
`default_nettype wire

// ---- sim/bdc_host_model.sv ----
// Host debugger model that hands decoded link commands to the block.
`timescale 1ns/100ps
`default_nettype none
module bdc_host_model
    import bdc_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic memCmdAccept, // Memory command allowed.
    input wire logic cpuCmdAccept, // CPU command allowed.
    input wire logic globalOut, // Global access applied.
    output logic cmdValid, // Command pulse.
    output var bdc_cmd_e cmdClass, // Command class.
    output logic cmdWrite, // Write command.
    output logic cmdDebugReg, // Debug register target.
    output logic cmdGlobal, // Global access asked.
    output logic cmdExitDebug, // Resume command.
    output logic [17:0] cmdAddr, // Address.
    output logic [7:0] cmdWrData // Write byte.
);
    logic memSeen;
    logic cpuSeen;
    logic globSeen;
    // Idle lines; the link decoder is quiet until the first command.
    initial begin
        cmdValid = 1'b0;
        cmdClass = BDC_CMD_NONE;
        {cmdWrite, cmdDebugReg, cmdGlobal, cmdExitDebug} = 4'h0;
        cmdAddr = 18'h00000;
        cmdWrData = 8'h00;
    end
    // One command for one cycle; stale address and data are inverted afterwards.
    task automatic send(input bdc_cmd_e c, input logic [3:0] f, input logic [17:0] a,
        input logic [7:0] v);
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmdClass = c;
        {cmdWrite, cmdDebugReg, cmdGlobal, cmdExitDebug} = f;
        cmdAddr = a;
        cmdWrData = v;
        #4;
        memSeen = memCmdAccept;
        cpuSeen = cpuCmdAccept;
        globSeen = globalOut;
        @(negedge core_clk);
        cmdValid = 1'b0;
        cmdClass = BDC_CMD_NONE;
        cmdAddr = ~cmdAddr;
        cmdWrData = ~cmdWrData;
    endtask : send
endmodule : bdc_host_model
`default_nettype wire

// ---- sim/background_debug_control_tb.sv ----
// Self-checking testbench of the background debug control block.
`timescale 1ns/100ps
`default_nettype none
module background_debug_control_tb;
    import bdc_pkg::*;
    logic core_clk, rst, specialMode, securedStrap, bgndInstr, brkTrigger, brkBefore;
    logic instrDone, globalAccessEnable, cmdValid, cmdWrite, cmdDebugReg, cmdGlobal;
    logic cmdExitDebug, memCmdAccept, cpuCmdAccept, globalOut, pagedOut, debugActive;
    logic debugEnable, unsecured, cpuHold, rdHit, userBlocked, flashErased, flashCheckDone;
    bdc_cmd_e cmdClass;
    logic [3:0] pageOut;
    logic [7:0] cpuCcr, cmdWrData, ccrRestore, rdData, v;
    logic [17:0] cpuPc, userAddr, cmdAddr, savedPc;
    int error_cnt = 0;
    int samples_checked = 0;
    integer seed = 32'h42AE;
    bdc_core i_bdc_core (.core_clk, .rst, .specialMode, .securedStrap,
        .flashErased, .flashCheckDone, .cmdValid, .cmdClass, .cmdWrite,
        .cmdDebugReg, .cmdGlobal, .cmdExitDebug, .cmdAddr, .cmdWrData, .globalAccessEnable,
        .bgndInstr, .brkTrigger, .brkBefore, .instrDone, .cpuCcr, .cpuPc, .userAddr,
        .memCmdAccept, .cpuCmdAccept, .globalOut, .pagedOut, .pageOut, .debugActive,
        .debugEnable, .unsecured, .cpuHold, .ccrRestore, .savedPc, .rdData, .rdHit,
        .userBlocked);
    bdc_host_model i_bdc_host_model (.core_clk, .memCmdAccept, .cpuCmdAccept, .globalOut,
        .cmdValid, .cmdClass, .cmdWrite, .cmdDebugReg, .cmdGlobal, .cmdExitDebug, .cmdAddr,
        .cmdWrData);
    // ------------------------------------------------------------------
    // Clock, random instruction completions and hang guard
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // The CPU finishes instructions at random moments.
    initial begin
        instrDone = 1'b0;
        forever begin
            @(negedge core_clk);
            instrDone = $random(seed) & 1;
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        check("runTime", 1, 0);
        final_report();
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // Bounded wait on debugActive (sel 0) or cpuHold (sel 1).
    task automatic waitBit(input int sel, input logic want);
        int n;
        n = 0;
        while (((sel == 0) ? debugActive : cpuHold) !== want && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        check("waitBit", (sel == 0) ? debugActive : cpuHold, want);
        if (((sel == 0) ? debugActive : cpuHold) !== want) final_report();
    endtask : waitBit
    task automatic doReset(input logic sp, input logic sec);
        @(negedge core_clk);
        rst = 1'b1;
        specialMode = sp;
        securedStrap = sec;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : doReset
    task automatic rdReg(input logic [17:0] a, input logic [7:0] e, input string nm);
        i_bdc_host_model.send(BDC_CMD_MEM, 4'h4, a, 8'h00);
        check(nm, rdData, e);
    endtask : rdReg
    task automatic eraseChk(input logic ok);
        doReset(1'b1, 1'b1);
        {flashErased, flashCheckDone} = {ok, 1'b1};
        @(negedge core_clk);
        flashCheckDone = 1'b0;
        check("erase", {debugEnable, unsecured, debugActive}, {1'b1, ok, ok});
        rdReg(BDC_CCH_ADDR, BDC_CCH_RST_SPECIAL, "eraseMem");
        i_bdc_host_model.send(BDC_CMD_CPU, 4'h8, 18'h00000, 8'h00);
        check("eraseCpu", i_bdc_host_model.cpuSeen, ok);
    endtask : eraseChk
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, specialMode, securedStrap, bgndInstr, brkTrigger, brkBefore} = 6'h20;
        globalAccessEnable = 1'b0;
        {flashErased, flashCheckDone} = 2'h0;
        cpuCcr = 8'h00;
        cpuPc = 18'h01234;
        userAddr = 18'h00100;
        doReset(1'b0, 1'b0);
        check("enable", debugEnable, 0);
        rdReg(BDC_CCH_ADDR, BDC_CCH_RST_OTHER, "holdReset");
        rdReg(BDC_PPR_ADDR, BDC_PPR_RST, "pageReset");
        check("memAcc", i_bdc_host_model.memSeen, 1);
        i_bdc_host_model.send(BDC_CMD_CPU, 4'h0, 18'h00000, 8'h00);
        check("cpuAcc", i_bdc_host_model.cpuSeen, 0);
        i_bdc_host_model.send(BDC_CMD_BKGND, 4'h0, 18'h00000, 8'h00);
        check("bgIgnored", {debugActive, cpuHold}, 0);
        @(negedge core_clk);
        bgndInstr = 1'b1;
        @(negedge core_clk);
        bgndInstr = 1'b0;
        waitBit(1, 1'b1);
        repeat (BDC_RESUME_CYC + 2) @(negedge core_clk);
        check("holdOff", {cpuHold, debugActive}, 0);
        $display("test disabled done");
        i_bdc_host_model.send(BDC_CMD_MEM, 4'hC, BDC_STATUS_ADDR, 8'h80);
        check("enable", debugEnable, 1);
        cpuCcr = $random(seed);
        i_bdc_host_model.send(BDC_CMD_BKGND, 4'h0, 18'h00000, 8'h00);
        waitBit(0, 1'b1);
        check("ccrSaved", ccrRestore, cpuCcr);
        rdReg(BDC_FID_ADDR, BDC_FAMILY_IDENTIFIER, "familyId");
        userAddr = BDC_WIN_BASE + 18'h00005;
        #1 check("userBlk", userBlocked, 1);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : $random(seed);
            i_bdc_host_model.send(BDC_CMD_MEM, 4'hC, BDC_PPR_ADDR, v);
            rdReg(BDC_PPR_ADDR, v & BDC_PPR_WMASK, "page");
            check("pageOut", {pagedOut, pageOut}, {v[7], v[3:0]});
            i_bdc_host_model.send(BDC_CMD_MEM, 4'hC, BDC_CCH_ADDR, ~v);
            rdReg(BDC_CCH_ADDR, ~v, "holdWrite");
            check("ccrRestore", ccrRestore, 8'(~v));
        end
        globalAccessEnable = 1'b1;
        i_bdc_host_model.send(BDC_CMD_MEM, 4'h6, BDC_PPR_ADDR, 8'h00);
        check("global", i_bdc_host_model.globSeen, 0);
        i_bdc_host_model.send(BDC_CMD_CPU, 4'h1, 18'h00000, 8'h00);
        waitBit(0, 1'b0);
        cpuPc = 18'h3FF20;
        brkBefore = 1'b1;
        @(negedge core_clk);
        brkTrigger = 1'b1;
        @(negedge core_clk);
        brkTrigger = 1'b0;
        waitBit(0, 1'b1);
        check("savedPc", savedPc, 18'h3FF21);
        i_bdc_host_model.send(BDC_CMD_CPU, 4'h8, 18'h00000, 8'h00);
        check("cpuAcc", i_bdc_host_model.cpuSeen, 1);
        i_bdc_host_model.send(BDC_CMD_CPU, 4'h1, 18'h00000, 8'h00);
        waitBit(0, 1'b0);
        $display("test active done");
        doReset(1'b1, 1'b0);
        check("specialUp", {debugEnable, debugActive}, 3);
        rdReg(BDC_CCH_ADDR, BDC_CCH_RST_SPECIAL, "holdSpecial");
        doReset(1'b0, 1'b1);
        i_bdc_host_model.send(BDC_CMD_MEM, 4'h4, BDC_PPR_ADDR, 8'h00);
        check("secMem", i_bdc_host_model.memSeen, 0);
        eraseChk(1'b0);
        eraseChk(1'b1);
        $display("test reset modes done");
        final_report();
    end
endmodule : background_debug_control_tb
`default_nettype wire
